// >>> include/gjk_regs.vh
`ifndef GJK_REGS_VH
`define GJK_REGS_VH

// Core clock period in nanoseconds (50 MHz)
`define GJK_CORE_PERIOD_NS       20

// Least widths the driving logic must respect, in nanoseconds
`define GJK_MIN_CLOCK_WIDTH_NS   200
`define GJK_MIN_PRESET_WIDTH_NS  100
`define GJK_MIN_CLEAR_WIDTH_NS   100

// Least widths as core clock cycles, rounded up
`define GJK_MIN_CLOCK_WIDTH_CYC  ((`GJK_MIN_CLOCK_WIDTH_NS + `GJK_CORE_PERIOD_NS - 1) / `GJK_CORE_PERIOD_NS)
`define GJK_MIN_PRESET_WIDTH_CYC ((`GJK_MIN_PRESET_WIDTH_NS + `GJK_CORE_PERIOD_NS - 1) / `GJK_CORE_PERIOD_NS)
`define GJK_MIN_CLEAR_WIDTH_CYC  ((`GJK_MIN_CLEAR_WIDTH_NS + `GJK_CORE_PERIOD_NS - 1) / `GJK_CORE_PERIOD_NS)

// Width of the clock-high cycle counter
`define GJK_HIGH_CNT_W           8

// Reset values of the stored state
`define GJK_STATE_RST            1'b0

`endif

// >>> design/gjk_sync.v
`timescale 1ns/10ps

// Two-flop synchroniser for a group of pin levels
module gjk_sync #(
    parameter W = 1
) (
    core_clk,
    arst_n,
    din,
    dout
);
    input  wire         core_clk;
    input  wire         arst_n;
    input  wire [W-1:0] din;
    output reg  [W-1:0] dout;

    reg [W-1:0] meta_r;

    // First stage feeds only the second stage
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_r <= {W{1'b0}};
            dout   <= {W{1'b0}};
        end else begin
            meta_r <= din;
            dout   <= meta_r;
        end
    end
endmodule // gjk_sync

// >>> design/gjk_flop.v
`timescale 1ns/10ps
`include "gjk_regs.vh"

//Contract
// - Set request is AND of three set gates; reset request AND of three reset gates.
// - Next state: both low hold, reset-only clear, set-only set, both high toggle.
// - New state reaches the outputs only on the clock pin's falling edge.
// - Requests are accepted once the clock pin is high.
// - Requests may change while clock is high; levels before the fall decide.
// - Low preset forces the true output high unless clear or core reset is also low.
// - Low clear forces the true output low.
// - Preset and clear act without a clock edge and override clocked updates.
module gjk_flop #(
    parameter MIN_CLK_CYC = `GJK_MIN_CLOCK_WIDTH_CYC
) (
    core_clk,
    arst_n,
    jk_clk,
    set_gate_a,
    set_gate_b,
    set_gate_c,
    reset_gate_a,
    reset_gate_b,
    reset_gate_c,
    preset_n,
    clear_n,
    q,
    q_n,
    clk_width_fault
);
    // Core side
    input  wire core_clk;
    input  wire arst_n;
    // Pin side, asynchronous to the core clock
    input  wire jk_clk;
    input  wire set_gate_a;
    input  wire set_gate_b;
    input  wire set_gate_c;
    input  wire reset_gate_a;
    input  wire reset_gate_b;
    input  wire reset_gate_c;
    input  wire preset_n;
    input  wire clear_n;
    // Outputs
    output wire q;
    output wire q_n;
    output reg  clk_width_fault;

    // Counter width and limits; the width parameter is cut to the counter, keep it below 256
    localparam CW = `GJK_HIGH_CNT_W;
    localparam [CW-1:0] MIN_CLK = MIN_CLK_CYC[CW-1:0];
    localparam [CW-1:0] CNT_MAX = {CW{1'b1}};
    localparam [CW-1:0] CNT_ONE = {{(CW-1){1'b0}}, 1'b1};

    // Request codes of the truth table, set request in the upper bit
    localparam [1:0] REQ_HOLD   = 2'b00;
    localparam [1:0] REQ_CLEAR  = 2'b01;
    localparam [1:0] REQ_SET    = 2'b10;
    localparam [1:0] REQ_TOGGLE = 2'b11;

    // Synchronised pin levels
    wire          clk_s;
    wire [2:0]    set_s;
    wire [2:0]    rst_s;
    // Requests captured while the clock pin is high
    reg           clk_d_r;
    reg           set_hold_r;
    reg           rst_hold_r;
    reg  [CW-1:0] high_cnt_r;
    // Stored state and its next value
    reg           q_r;
    reg           q_n_r;
    reg           q_nxt;
    // Force chains for preset and clear
    reg           pre_m_r;
    reg           pre_act_n_r;
    reg           clr_m_r;
    reg           clr_act_n_r;
    // Combinational helpers
    wire          set_req;
    wire          rst_req;
    wire [1:0]    req_code;
    wire          fall;
    wire          fall_ok;
    wire          clr_rst_n;
    wire          q_lo_n;
    wire          q_hi_n;

    // Pin levels pass two flops; gates share the clock's latency so they stay aligned
    // Trade-off: the clock and gate pins pay two cycles of latency, none of them is read raw
    gjk_sync #(.W(7)) u_sync (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .din      ({jk_clk, set_gate_c, set_gate_b, set_gate_a,
                    reset_gate_c, reset_gate_b, reset_gate_a}),
        .dout     ({clk_s, set_s, rst_s})
    );

    // Effective requests; all three gates of a group must be high
    // Gates are synced together, so a group never mixes two cycles
    assign set_req = &set_s;
    assign rst_req = &rst_s;

    // Falling edge of the clock pin seen in the core domain
    // Uses the synced copy, so it lands two core cycles after the pin
    assign fall    = clk_d_r & ~clk_s;
    // Too-short pulses are not recognised as updates
    // Refused rather than acted on; the fault flag reports them
    assign fall_ok = fall & (high_cnt_r >= MIN_CLK);

    // Capture requests while the clock is high; last high-cycle value counts
    // Counter saturates so a very long high pulse never looks short
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            clk_d_r    <= 1'b0;
            set_hold_r <= 1'b0;
            rst_hold_r <= 1'b0;
            high_cnt_r <= {CW{1'b0}};
        end else begin
            clk_d_r <= clk_s;
            if (clk_s) begin
                set_hold_r <= set_req;
                rst_hold_r <= rst_req;
                if (high_cnt_r != CNT_MAX) begin
                    high_cnt_r <= high_cnt_r + CNT_ONE;
                end
            end else begin
                high_cnt_r <= {CW{1'b0}};
            end
        end
    end

    // Flags a falling edge that came before the least clock width
    // One-cycle pulse; the refused edge leaves the stored state alone
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            clk_width_fault <= 1'b0;
        end else begin
            clk_width_fault <= fall & ~fall_ok;
        end
    end

    // Captured requests as one code for the truth table
    assign req_code = {set_hold_r, rst_hold_r};

    // Truth table of the bistable; the default only covers unknown codes
    always @* begin
        case (req_code)
            REQ_HOLD:   q_nxt = q_r;
            REQ_CLEAR:  q_nxt = 1'b0;
            REQ_SET:    q_nxt = 1'b1;
            REQ_TOGGLE: q_nxt = ~q_r;
            default:    q_nxt = q_r;
        endcase
    end

    // Preset and clear assert at once and release through two flops,
    // so release never races the core clock; core reset acts like clear
    assign clr_rst_n = arst_n & clear_n;

    // Preset chain sits released during core reset: if both chains let go
    // on one edge, a zero-width dip on the set force could set the state
    always @(posedge core_clk or negedge arst_n or negedge preset_n) begin
        if (!arst_n) begin
            pre_m_r     <= 1'b1;
            pre_act_n_r <= 1'b1;
        end else if (!preset_n) begin
            pre_m_r     <= 1'b0;
            pre_act_n_r <= 1'b0;
        end else begin
            pre_m_r     <= 1'b1;
            pre_act_n_r <= pre_m_r;
        end
    end

    // Clear chain, also held by core reset
    always @(posedge core_clk or negedge clr_rst_n) begin
        if (!clr_rst_n) begin
            clr_m_r     <= 1'b0;
            clr_act_n_r <= 1'b0;
        end else begin
            clr_m_r     <= 1'b1;
            clr_act_n_r <= clr_m_r;
        end
    end

    // Clear wins over preset when both are low; core reset acts like clear
    assign q_lo_n = clr_act_n_r;
    assign q_hi_n = pre_act_n_r | ~clr_act_n_r;

    // Stored state; asynchronous forces override the clocked update
    // Clear is tested first, so clear wins when both pins are low
    always @(posedge core_clk or negedge q_lo_n or negedge q_hi_n) begin
        if (!q_lo_n) begin
            q_r <= `GJK_STATE_RST;
        end else if (!q_hi_n) begin
            q_r <= 1'b1;
        end else if (fall_ok) begin
            q_r <= q_nxt;
        end
    end

    // Complement kept in its own flop with mirrored forces
    // so q_n is a register output and never an inverter behind q
    always @(posedge core_clk or negedge q_lo_n or negedge q_hi_n) begin
        if (!q_lo_n) begin
            q_n_r <= ~`GJK_STATE_RST;
        end else if (!q_hi_n) begin
            q_n_r <= 1'b0;
        end else if (fall_ok) begin
            q_n_r <= ~q_nxt;
        end
    end

    // Outputs straight from the state flops
    assign q   = q_r;
    assign q_n = q_n_r;
endmodule // gjk_flop

// >>> test/gjk_flop_sva.sv
`timescale 1ns/10ps
// Watches the bistable pins on the core clock
module gjk_chk (
    input wire core_clk, arst_n, jk_clk, preset_n, clear_n, q, q_n, clk_width_fault,
    input wire set_gate_a, set_gate_b, set_gate_c, reset_gate_a, reset_gate_b, reset_gate_c
);
    wire s = set_gate_a & set_gate_b & set_gate_c;
    wire r = reset_gate_a & reset_gate_b & reset_gate_c;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    // Only a fall after a long enough high, with no forcing, counts
    sequence fl;
        $fell(jk_clk) && $past(jk_clk, 3) && preset_n && clear_n;
    endsequence
    property p_comp; q_n == !q; endproperty
    a_comp: assert property (p_comp) else $error("q_n not inverse");
    property p_pre; !preset_n && clear_n |-> q; endproperty
    a_pre: assert property (p_pre) else $error("preset ignored");
    property p_clr; !clear_n |-> !q; endproperty
    a_clr: assert property (p_clr) else $error("clear ignored");
    property p_still; (jk_clk && preset_n && clear_n) [*6] |-> $stable(q); endproperty
    a_still: assert property (p_still) else $error("q moved while high");
    property p_flt; clk_width_fault |=> !clk_width_fault; endproperty
    a_flt: assert property (p_flt) else $error("fault too long");
    property p_set; fl ##0 (s && !r) |-> ##[3:5] q; endproperty
    a_set: assert property (p_set) else $error("set missed");
    property p_rst; fl ##0 (!s && r) |-> ##[3:5] !q; endproperty
    a_rst: assert property (p_rst) else $error("reset missed");
    property p_tog; fl ##0 (s && r) |-> ##[3:5] $changed(q); endproperty
    a_tog: assert property (p_tog) else $error("toggle missed");
    property p_hold; fl ##0 (!s && !r) |=> $stable(q) [*5]; endproperty
    a_hold: assert property (p_hold) else $error("hold broken");
endmodule // gjk_chk
bind gjk_flop gjk_chk u_chk (
    .core_clk        (core_clk),
    .arst_n          (arst_n),
    .jk_clk          (jk_clk),
    .preset_n        (preset_n),
    .clear_n         (clear_n),
    .q               (q),
    .q_n             (q_n),
    .clk_width_fault (clk_width_fault),
    .set_gate_a      (set_gate_a),
    .set_gate_b      (set_gate_b),
    .set_gate_c      (set_gate_c),
    .reset_gate_a    (reset_gate_a),
    .reset_gate_b    (reset_gate_b),
    .reset_gate_c    (reset_gate_c)
);

// >>> test/gjk_env.sv
`timescale 1ns/10ps
// Surrounding logic: clock pulses and the gates around them
module gjk_env (
    input  wire       core_clk,
    output reg        jk_clk,
    output reg  [5:0] gates
);
    initial jk_clk = 1'b0;
    initial gates = 6'h00;
    // Gates start wrong on pulses over 3 cycles and settle at the third cycle, before the fall
    task pulse(input int hi, input [5:0] g);
        int k;
        @(negedge core_clk) jk_clk = 1'b1;
        gates = (hi > 3) ? ~g : g;
        for (k = 1; k <= hi; k++) begin
            @(negedge core_clk);
            if (k == 3) gates = g;
        end
        jk_clk = 1'b0;
        repeat (8) @(negedge core_clk);
    endtask
endmodule // gjk_env

// >>> test/testbench.sv
`timescale 1ns/10ps
// Runs the bistable through its modes
module testbench;
    logic        core_clk, arst_n, preset_n, clear_n, q, q_n, flt, jk_clk, qe, seen;
    logic [5:0]  g;
    logic [31:0] r;
    int          n_fail, checks, i;
    gjk_env u_gjk_env (.core_clk(core_clk), .jk_clk(jk_clk), .gates(g));
    gjk_flop #(.MIN_CLK_CYC(2)) u_gjk_flop (.core_clk(core_clk), .arst_n(arst_n),
        .jk_clk(jk_clk), .set_gate_a(g[5]), .set_gate_b(g[4]), .set_gate_c(g[3]),
        .reset_gate_a(g[2]), .reset_gate_b(g[1]), .reset_gate_c(g[0]),
        .preset_n(preset_n), .clear_n(clear_n), .q(q), .q_n(q_n), .clk_width_fault(flt));
    // A gate group counts only when all three are high
    function logic nxt(input logic c, input [5:0] v);
        return (&v[5:3] && &v[2:0]) ? !c : &v[5:3] ? 1'b1 : &v[2:0] ? 1'b0 : c;
    endfunction
    function logic [31:0] lfsr(input [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task chk(input logic e);
        checks++;
        if (q !== e || q_n !== !e) begin
            n_fail++;
            $display("unexpected at %0t: q=%b q_n=%b want %b", $time, q, q_n, e);
        end
    endtask
    task chk_flt(input logic e);
        checks++;
        if (seen !== e) begin
            n_fail++;
            $display("unexpected at %0t: width fault seen=%b want %b", $time, seen, e);
        end
    endtask
    task finish_test;
        if (n_fail == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task step(input [5:0] v);
        u_gjk_env.pulse(10, v);
        qe = nxt(qe, v);
        chk(qe);
    endtask
    // One forcing pin low for 5 cycles; it must act before any edge
    task force_pin(input logic pre);
        @(negedge core_clk) {preset_n, clear_n} = {!pre, pre};
        #1 chk(pre);
        repeat (5) @(negedge core_clk);
        {preset_n, clear_n} = 2'b11;
        repeat (3) @(negedge core_clk);
        qe = pre;
        chk(qe);
    endtask
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = !core_clk;
    end
    initial begin
        {arst_n, preset_n, clear_n, qe, seen} = 5'h0c;
        n_fail = 0;
        checks = 0;
        r = 32'haf976841;
        repeat (3) @(negedge core_clk);
        arst_n = 1'b1;
        repeat (3) @(negedge core_clk);
        chk(1'b0);
        for (i = 0; i < 4; i++) step({{3{i[1]}}, {3{i[0]}}});
        step(6'h3f);
        force_pin(1'b1);
        force_pin(1'b0);
        // A one-cycle pulse with set gates must be refused and flagged
        fork
            u_gjk_env.pulse(1, 6'h38);
            repeat (12) @(negedge core_clk) seen |= flt;
        join
        chk(qe);
        chk_flt(1'b1);
        for (i = 0; i < 40; i++) begin
            r = lfsr(r);
            step(r[5:0]);
        end
        finish_test;
    end
endmodule // testbench
